// ==== frx_consts.vh ====
/*
 * Constants for the fieldbus register exchange: holding-register numbers,
 * function codes, exception codes, sentinel words and timing figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FRX_CONSTS_VH
`define FRX_CONSTS_VH

// holding-register numbers, 1-based as the master addresses them
`define FRX_TO_FIRST 16'h0001
`define FRX_TO_LAST 16'h0100
`define FRX_FROM_FIRST 16'h0101
`define FRX_FROM_LAST 16'h0200
`define FRX_REG_TIMEOUT 16'h0204
`define FRX_REG_IDLE 16'h0205
`define FRX_TIMEOUT_RST 16'h0000
`define FRX_IDLE_RST 16'h0000

// function codes
`define FRX_FC_READ 8'h03
`define FRX_FC_WRITE1 8'h06
`define FRX_FC_WRITEN 8'h10
`define FRX_FC_RDWR 8'h17
`define FRX_FC_DEVID 8'h2B
`define FRX_SUB_DEVID 8'h0E

// exception codes, zero means a normal answer
`define FRX_EXC_NONE 8'h00
`define FRX_EXC_FUNC 8'h01
`define FRX_EXC_ADDR 8'h02
`define FRX_EXC_VALUE 8'h03

// sentinel words
`define FRX_SENT_HI 16'h8000
`define FRX_SENT_LO 16'h0000
`define FRX_SENT_32 32'h8000_0000

// timing: clock in kHz, so cycles per millisecond is the same figure
`define FRX_CLK_KHZ 200000
`define FRX_MS_CYCLES (`FRX_CLK_KHZ * 1)
`endif

// ==== frx_exchange.v ====
/*
 * Fieldbus register exchange: holding registers between a Modbus master and
 * the drive application, with sentinel and cyclic-mode update behaviour.
 * Assumes a frame parser ahead of it that splits each request into one word
 * per cycle, and an application that accepts one input event per cycle.
 */
// Summary of operation
// - in sentinel modes unwritten values read as 8000h or 80000000h
// - in sentinel modes output registers keep the sentinel until the application writes them
// - in sentinel modes input events are raised only for values differing from the sentinel
// - cyclic mode holds input events until running, then updates all inputs
// - cyclic mode zeroes all inputs when the link leaves running
// - cyclic mode outputs read zero until the application writes them
// - function codes 3, 6, 16, 23 and 43/14 are served, others refused
// - registers 1-256 go to the drive, 257-512 come from it
// - register 516 holds the timeout in ms, zero disables it
// - timeout writes are passed to nonvolatile storage and reloaded
// - register 517: zero leaves idle, any nonzero value enters idle
// - 32-bit values span two registers, word order selectable
`timescale 1ns/1ps
`include "frx_consts.vh"

module frx_exchange #(
    parameter N = 256,
    parameter MS_CYCLES = `FRX_MS_CYCLES,
    parameter [15:0] ID_VENDOR = 16'h1234, // arbitrary value
    parameter [15:0] ID_PRODUCT = 16'h5678, // arbitrary value
    parameter [15:0] ID_REVISION = 16'h0001 // arbitrary value
) (
    input wire CLK,
    input wire RST,
    input wire MODE_CYCLIC,
    input wire LINK_RUNNING,
    input wire HIGH_WORD_FIRST,
    input wire [N-1:0] WIDE_IN,
    input wire [N-1:0] WIDE_OUT,
    input wire [15:0] PARAM_SET_SIZE,
    input wire REQ_VALID,
    output wire REQ_READY,
    input wire [7:0] REQ_FUNC,
    input wire [7:0] REQ_SUB,
    input wire REQ_WRITE,
    input wire [15:0] REQ_REG,
    input wire [15:0] REQ_COUNT,
    input wire [15:0] REQ_WDATA,
    output reg RSP_VALID,
    output reg [15:0] RSP_RDATA,
    output reg [7:0] RSP_EXC,
    output reg APP_IN_VALID,
    output reg [7:0] APP_IN_IDX,
    output reg [31:0] APP_IN_DATA,
    output reg APP_IN_ZERO,
    input wire APP_OUT_WE,
    input wire [7:0] APP_OUT_IDX,
    input wire APP_OUT_WIDE,
    input wire [31:0] APP_OUT_DATA,
    input wire [15:0] NV_TIMEOUT,
    output reg NV_WE,
    output reg [15:0] NV_WDATA,
    output reg IDLE,
    output wire CONN_LOST,
    output wire [15:0] TIMEOUT_MS
);
    localparam S_OPEN = 4'b0001;
    localparam S_HOLD = 4'b0010;
    localparam S_SCAN = 4'b0100;
    localparam S_RUN = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [15:0] to_drv [0:N-1];
    reg [15:0] from_drv [0:N-1];
    reg [N-1:0] to_wr;
    reg [N-1:0] from_wr;
    reg [15:0] timeout_ms;
    reg [15:0] idle_req;
    reg nv_loaded;
    reg [7:0] scan_idx;
    integer i, j;

    // sentinel for one word of a value; wide values split per word order
    function [15:0] sent_word;
        input first;
        input second;
        input hifirst;
        begin
            if (first)
                sent_word = hifirst ? `FRX_SENT_HI : `FRX_SENT_LO;
            else if (second)
                sent_word = hifirst ? `FRX_SENT_LO : `FRX_SENT_HI;
            else
                sent_word = `FRX_SENT_HI;
        end
    endfunction

    // assemble an application value from the completing word and its partner
    function [31:0] compose;
        input [15:0] cur;
        input [15:0] prev;
        input second;
        input hifirst;
        begin
            if (!second)
                compose = {16'h0000, cur};
            else if (hifirst)
                compose = {prev, cur};
            else
                compose = {cur, prev};
        end
    endfunction

    // request decode: region 1 to-drive, 2 from-drive, 3 timeout, 4 idle
    function [2:0] region;
        input [15:0] r;
        begin
            if (r >= `FRX_TO_FIRST && r <= `FRX_TO_LAST)
                region = 3'd1;
            else if (r >= `FRX_FROM_FIRST && r <= `FRX_FROM_LAST)
                region = 3'd2;
            else if (r == `FRX_REG_TIMEOUT)
                region = 3'd3;
            else if (r == `FRX_REG_IDLE)
                region = 3'd4;
            else
                region = 3'd0;
        end
    endfunction

    wire sentinel_mode = !MODE_CYCLIC;
    wire [2:0] req_region = region(REQ_REG);
    wire [7:0] to_idx = REQ_REG[7:0] - 8'h01;
    wire [7:0] from_idx = REQ_REG[7:0] - 8'h01;
    wire [7:0] to_prev = to_idx - 8'h01;
    wire [7:0] from_prev = from_idx - 8'h01;
    wire to_second = (to_idx != 8'h00) && WIDE_IN[to_prev];
    wire from_second = (from_idx != 8'h00) && WIDE_OUT[from_prev];
    wire [7:0] scan_prev = scan_idx - 8'h01;
    wire scan_second = (scan_idx != 8'h00) && WIDE_IN[scan_prev];

    // frame parser is stalled while the running-entry burst owns the event port
    assign REQ_READY = (state != S_SCAN);
    wire req_take = REQ_VALID && REQ_READY;

    // function / direction legality
    wire fc_read = (REQ_FUNC == `FRX_FC_READ) && !REQ_WRITE;
    wire fc_write = (REQ_FUNC == `FRX_FC_WRITE1 || REQ_FUNC == `FRX_FC_WRITEN) && REQ_WRITE;
    wire fc_rdwr = (REQ_FUNC == `FRX_FC_RDWR);
    wire fc_devid = (REQ_FUNC == `FRX_FC_DEVID) && (REQ_SUB == `FRX_SUB_DEVID);
    wire fc_ok = fc_read || fc_write || fc_rdwr || fc_devid;
    wire do_write = fc_write || (fc_rdwr && REQ_WRITE);
    // the count is checked against the parameter set size; excess is refused
    wire count_bad = (REQ_COUNT > PARAM_SET_SIZE);
    wire addr_bad = !fc_devid && (req_region == 3'd0);
    wire req_ok = req_take && fc_ok && !addr_bad && !count_bad;
    wire wr_to = req_ok && do_write && req_region == 3'd1;

    // input event from a master write, complete values only
    wire [31:0] wr_value = compose(REQ_WDATA, to_drv[to_prev], to_second, HIGH_WORD_FIRST);
    wire wr_complete = !WIDE_IN[to_idx];
    wire wr_is_sent = to_second ? (wr_value == `FRX_SENT_32) : (REQ_WDATA == `FRX_SENT_HI);
    wire wr_event = wr_to && wr_complete && (sentinel_mode ? !wr_is_sent : (state == S_RUN));

    always @*
    begin
        next_state = state;
        case (state)
            S_OPEN:
                if (MODE_CYCLIC)
                    next_state = LINK_RUNNING ? S_SCAN : S_HOLD;
            S_HOLD:
                if (!MODE_CYCLIC)
                    next_state = S_OPEN;
                else if (LINK_RUNNING)
                    next_state = S_SCAN;
            S_SCAN:
                if (!LINK_RUNNING || !MODE_CYCLIC)
                    next_state = MODE_CYCLIC ? S_HOLD : S_OPEN;
                else if (scan_idx == N - 1)
                    next_state = S_RUN;
            S_RUN:
                if (!MODE_CYCLIC)
                    next_state = S_OPEN;
                else if (!LINK_RUNNING)
                    next_state = S_HOLD;
            default:
                next_state = S_OPEN;
        endcase
    end

    wire leave_run = MODE_CYCLIC && (state == S_RUN || state == S_SCAN) && !LINK_RUNNING;

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= S_OPEN;
            scan_idx <= 8'h00;
            APP_IN_VALID <= 1'b0;
            APP_IN_IDX <= 8'h00;
            APP_IN_DATA <= 32'h0000_0000;
            APP_IN_ZERO <= 1'b0;
            to_wr <= {N{1'b0}};
            for (i = 0; i < N; i = i + 1)
                to_drv[i] <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            APP_IN_VALID <= 1'b0;
            APP_IN_ZERO <= 1'b0;
            scan_idx <= (state == S_SCAN) ? scan_idx + 8'h01 : 8'h00;
            if (leave_run)
            begin
                to_wr <= {N{1'b0}};
                for (i = 0; i < N; i = i + 1)
                    to_drv[i] <= 16'h0000;
                APP_IN_ZERO <= 1'b1;
            end
            else
            begin
                if (wr_to)
                begin
                    to_drv[to_idx] <= REQ_WDATA;
                    to_wr[to_idx] <= 1'b1;
                end
                if (state == S_SCAN && !WIDE_IN[scan_idx])
                begin
                    APP_IN_VALID <= 1'b1;
                    APP_IN_IDX <= scan_idx;
                    APP_IN_DATA <= compose(to_drv[scan_idx], to_drv[scan_prev],
                        scan_second, HIGH_WORD_FIRST);
                end
                else if (wr_event)
                begin
                    APP_IN_VALID <= 1'b1;
                    APP_IN_IDX <= to_idx;
                    APP_IN_DATA <= wr_value;
                end
            end
        end
    end

    // application writes into the from-drive registers
    wire [7:0] out_next = APP_OUT_IDX + 8'h01;
    wire [15:0] out_first = HIGH_WORD_FIRST ? APP_OUT_DATA[31:16] : APP_OUT_DATA[15:0];
    wire [15:0] out_second = HIGH_WORD_FIRST ? APP_OUT_DATA[15:0] : APP_OUT_DATA[31:16];

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            from_wr <= {N{1'b0}};
            for (j = 0; j < N; j = j + 1)
                from_drv[j] <= 16'h0000;
        end
        else if (APP_OUT_WE)
        begin
            if (APP_OUT_WIDE)
            begin
                from_drv[APP_OUT_IDX] <= out_first;
                from_drv[out_next] <= out_second;
                from_wr[APP_OUT_IDX] <= 1'b1;
                from_wr[out_next] <= 1'b1;
            end
            else
            begin
                from_drv[APP_OUT_IDX] <= APP_OUT_DATA[15:0];
                from_wr[APP_OUT_IDX] <= 1'b1;
            end
        end
    end

    // control registers; the stored timeout is reloaded once after reset
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            timeout_ms <= `FRX_TIMEOUT_RST;
            idle_req <= `FRX_IDLE_RST;
            IDLE <= 1'b0;
            nv_loaded <= 1'b0;
            NV_WE <= 1'b0;
            NV_WDATA <= 16'h0000;
        end
        else
        begin
            NV_WE <= 1'b0;
            nv_loaded <= 1'b1;
            if (!nv_loaded)
                timeout_ms <= NV_TIMEOUT;
            else if (req_ok && do_write && req_region == 3'd3)
            begin
                timeout_ms <= REQ_WDATA;
                NV_WE <= 1'b1;
                NV_WDATA <= REQ_WDATA;
            end
            if (req_ok && do_write && req_region == 3'd4)
            begin
                idle_req <= REQ_WDATA;
                IDLE <= (REQ_WDATA != 16'h0000);
            end
        end
    end

    // read data: unwritten words show the sentinel or zero by mode
    reg [15:0] rd_word;
    always @*
    begin
        rd_word = 16'h0000;
        if (fc_devid)
        begin
            case (REQ_REG)
                16'h0000: rd_word = ID_VENDOR;
                16'h0001: rd_word = ID_PRODUCT;
                default: rd_word = ID_REVISION;
            endcase
        end
        else
        begin
            case (req_region)
                3'd1:
                    if (to_wr[to_idx])
                        rd_word = to_drv[to_idx];
                    else if (sentinel_mode)
                        rd_word = sent_word(WIDE_IN[to_idx], to_second,
                            HIGH_WORD_FIRST);
                3'd2:
                    if (from_wr[from_idx])
                        rd_word = from_drv[from_idx];
                    else if (sentinel_mode)
                        rd_word = sent_word(WIDE_OUT[from_idx], from_second,
                            HIGH_WORD_FIRST);
                    else
                        rd_word = 16'h0000;
                3'd3: rd_word = timeout_ms;
                3'd4: rd_word = idle_req;
                default: rd_word = 16'h0000;
            endcase
        end
    end

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 16'h0000;
            RSP_EXC <= `FRX_EXC_NONE;
        end
        else
        begin
            RSP_VALID <= req_take;
            if (req_take)
            begin
                RSP_RDATA <= (req_ok && !do_write) ? rd_word : 16'h0000;
                if (!fc_ok)
                    RSP_EXC <= `FRX_EXC_FUNC;
                else if (count_bad)
                    RSP_EXC <= `FRX_EXC_VALUE;
                else if (addr_bad)
                    RSP_EXC <= `FRX_EXC_ADDR;
                else
                    RSP_EXC <= `FRX_EXC_NONE;
            end
        end
    end

    frx_timeout #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timeout (
        .clk(CLK),
        .rst(RST),
        .kick(req_ok),
        .limit_ms(timeout_ms),
        .lost(CONN_LOST)
    );

    assign TIMEOUT_MS = timeout_ms;
endmodule // frx_exchange

// ==== frx_exchange_asserts.sv ====
/*
 * Concurrent checks on the exchange block's request, register and event ports.
 * Assumes it is bound to frx_exchange and sees only that module's ports.
 */
`timescale 1ns/1ps
module frx_exchange_asserts (
    input wire CLK,
    input wire RST,
    input wire MODE_CYCLIC,
    input wire LINK_RUNNING,
    input wire [15:0] PARAM_SET_SIZE,
    input wire REQ_VALID,
    input wire REQ_READY,
    input wire [7:0] REQ_FUNC,
    input wire REQ_WRITE,
    input wire [15:0] REQ_REG,
    input wire [15:0] REQ_COUNT,
    input wire [15:0] REQ_WDATA,
    input wire RSP_VALID,
    input wire [7:0] RSP_EXC,
    input wire APP_IN_VALID,
    input wire [31:0] APP_IN_DATA,
    input wire APP_IN_ZERO,
    input wire NV_WE,
    input wire [15:0] NV_WDATA,
    input wire IDLE,
    input wire CONN_LOST,
    input wire [15:0] TIMEOUT_MS
);
    wire take = REQ_VALID && REQ_READY;
    wire fit = take && REQ_COUNT <= PARAM_SET_SIZE;
    wire rd3 = REQ_FUNC == 8'h03 && !REQ_WRITE;
    wire wr6 = fit && REQ_FUNC == 8'h06 && REQ_WRITE;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    AST_ANSWER: assert property (take |=> RSP_VALID)
        else $error("taken request not answered");
    AST_NO_SPURIOUS: assert property (RSP_VALID |-> $past(take))
        else $error("answer without request");
    AST_BAD_FUNC: assert property (take && REQ_FUNC == 8'h04 |=> RSP_EXC == 8'h01)
        else $error("unsupported function not refused");
    AST_RANGE: assert property (fit && rd3 && REQ_REG > 16'h0205 |=> RSP_EXC == 8'h02)
        else $error("unmapped register not refused");
    AST_OVER: assert property (take && rd3 && !fit |=> RSP_EXC == 8'h03)
        else $error("oversized count not refused");
    AST_TIMEOUT_REG: assert property (wr6 && REQ_REG == 16'h0204 |=>
        TIMEOUT_MS == $past(REQ_WDATA) && NV_WE && NV_WDATA == $past(REQ_WDATA))
        else $error("timeout write not applied or stored");
    AST_IDLE_SET: assert property (wr6 && REQ_REG == 16'h0205 |=>
        IDLE == ($past(REQ_WDATA) != 16'h0000))
        else $error("idle state does not follow write");
    AST_LOST_OFF: assert property (TIMEOUT_MS == 16'h0000
        && $past(TIMEOUT_MS) == 16'h0000 && $past(TIMEOUT_MS, 2) == 16'h0000 |-> !CONN_LOST)
        else $error("connection lost with timeout disabled");
    AST_ZERO: assert property (MODE_CYCLIC && $fell(LINK_RUNNING) |=> APP_IN_ZERO)
        else $error("inputs not zeroed on leaving running");
    AST_HOLD: assert property (MODE_CYCLIC && !LINK_RUNNING && !$past(LINK_RUNNING)
        && !$past(LINK_RUNNING, 2) |-> !APP_IN_VALID)
        else $error("input event while link not running");
    AST_SENT32: assert property (!MODE_CYCLIC && APP_IN_VALID |->
        APP_IN_DATA != 32'h8000_0000)
        else $error("sentinel value passed to application");
endmodule // frx_exchange_asserts

bind frx_exchange frx_exchange_asserts u_chk (
    .CLK(CLK), .RST(RST), .MODE_CYCLIC(MODE_CYCLIC), .LINK_RUNNING(LINK_RUNNING),
    .PARAM_SET_SIZE(PARAM_SET_SIZE), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_FUNC(REQ_FUNC), .REQ_WRITE(REQ_WRITE), .REQ_REG(REQ_REG), .REQ_COUNT(REQ_COUNT),
    .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_EXC(RSP_EXC),
    .APP_IN_VALID(APP_IN_VALID), .APP_IN_DATA(APP_IN_DATA), .APP_IN_ZERO(APP_IN_ZERO),
    .NV_WE(NV_WE), .NV_WDATA(NV_WDATA), .IDLE(IDLE), .CONN_LOST(CONN_LOST),
    .TIMEOUT_MS(TIMEOUT_MS)
);

// ==== frx_master_model.sv ====
/*
 * Far-side model: a one-word-per-request master and the nonvolatile store of the timeout.
 * Assumes send is called from one process at a time.
 */
`timescale 1ns/1ps
module frx_master_model (
    input wire clk,
    input wire req_ready,
    input wire rsp_valid,
    input wire [15:0] rsp_rdata,
    input wire [7:0] rsp_exc,
    input wire nv_we,
    input wire [15:0] nv_wdata,
    output reg req_valid,
    output reg [7:0] req_func,
    output reg [7:0] req_sub,
    output reg req_write,
    output reg [15:0] req_reg,
    output reg [15:0] req_count,
    output reg [15:0] req_wdata,
    output reg [15:0] nv_timeout
);
    initial
    begin
        req_valid = 1'b0;
        req_func = 8'h00;
        req_sub = 8'h00;
        req_write = 1'b0;
        req_reg = 16'h0000;
        req_count = 16'h0001;
        req_wdata = 16'h0000;
        nv_timeout = 16'h0000;
    end

    // not reset: the store must outlive every reset of the block
    always @(posedge clk)
    begin
        if (nv_we === 1'b1)
            nv_timeout <= nv_wdata;
    end

    task send(input [7:0] f, input [7:0] s, input w, input [15:0] r, input [15:0] c,
        input [15:0] d, output v, output [15:0] rd, output [7:0] ex);
        integer n;
        begin
            @(negedge clk);
            req_valid = 1'b1;
            req_func = f;
            req_sub = s;
            req_write = w;
            req_reg = r;
            req_count = c;
            req_wdata = d;
            n = 0;
            while (req_ready !== 1'b1 && n < 400)
            begin
                @(negedge clk);
                n = n + 1;
            end
            @(negedge clk);
            req_valid = 1'b0;
            // released data line must not keep showing the last word
            req_wdata = ~d;
            v = rsp_valid;
            rd = rsp_rdata;
            ex = rsp_exc;
        end
    endtask
endmodule // frx_master_model

// ==== frx_timeout.v ====
/*
 * Connection watchdog: counts whole milliseconds since the last valid
 * request and raises a lost flag once the count passes the programmed limit.
 * Assumes a single clock; a limit of zero keeps the flag low.
 */
`timescale 1ns/1ps
`include "frx_consts.vh"

module frx_timeout #(
    parameter MS_CYCLES = `FRX_MS_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire kick,
    input wire [15:0] limit_ms,
    output reg lost
);
    reg [31:0] cyc;
    reg [16:0] ms;
    wire tick = (cyc == MS_CYCLES - 1);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cyc <= 32'h0000_0000;
            ms <= 17'h0_0000;
            lost <= 1'b0;
        end
        else if (kick || limit_ms == 16'h0000)
        begin
            cyc <= 32'h0000_0000;
            ms <= 17'h0_0000;
            lost <= 1'b0;
        end
        else
        begin
            cyc <= tick ? 32'h0000_0000 : cyc + 32'h0000_0001;
            // saturate so a long silence never wraps back under the limit
            if (tick && !ms[16])
                ms <= ms + 17'h0_0001;
            if (ms > {1'b0, limit_ms})
                lost <= 1'b1;
        end
    end
endmodule // frx_timeout

// ==== test_fieldbus_register_exchange.sv ====
/*
 * Self-checking bench: drives the master model, application side and link, compares answers.
 * Assumes a 200 MHz clock and a shortened millisecond of 10 cycles.
 */
`timescale 1ns/1ps
module test_fieldbus_register_exchange;
    localparam [15:0] VEN = 16'h0A5C; // arbitrary value
    localparam [15:0] PRD = 16'h3C3C; // arbitrary value
    reg clk, rst, mode_cyclic, link_running, hwf, app_we, app_wide, v;
    reg [255:0] wide_in;
    reg [15:0] rd;
    reg [7:0] ex, ev_idx;
    reg [31:0] ev_data, ev2;
    reg [55:0] tab [0:9];
    wire req_valid, req_ready, req_write, rsp_valid, app_in_valid, app_in_zero;
    wire nv_we, idle, conn_lost;
    wire [7:0] req_func, req_sub, rsp_exc, app_in_idx;
    wire [15:0] req_reg, req_count, req_wdata, rsp_rdata, nv_timeout, nv_wdata, timeout_ms;
    wire [31:0] app_in_data;
    integer mismatches, checked, cycles, ev_cnt, zc, e0, i;

    frx_exchange #(.MS_CYCLES(10), .ID_VENDOR(VEN), .ID_PRODUCT(PRD)) dut (
        .CLK(clk), .RST(rst), .MODE_CYCLIC(mode_cyclic), .LINK_RUNNING(link_running),
        .HIGH_WORD_FIRST(hwf), .WIDE_IN(wide_in), .WIDE_OUT(256'h0), .PARAM_SET_SIZE(16'h0010),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_FUNC(req_func), .REQ_SUB(req_sub),
        .REQ_WRITE(req_write), .REQ_REG(req_reg), .REQ_COUNT(req_count),
        .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_EXC(rsp_exc),
        .APP_IN_VALID(app_in_valid), .APP_IN_IDX(app_in_idx), .APP_IN_DATA(app_in_data),
        .APP_IN_ZERO(app_in_zero), .APP_OUT_WE(app_we), .APP_OUT_IDX(8'h00),
        .APP_OUT_WIDE(app_wide), .APP_OUT_DATA(32'h0000_55AA), .NV_TIMEOUT(nv_timeout),
        .NV_WE(nv_we), .NV_WDATA(nv_wdata), .IDLE(idle), .CONN_LOST(conn_lost),
        .TIMEOUT_MS(timeout_ms)
    );

    frx_master_model m (
        .clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_exc(rsp_exc), .nv_we(nv_we), .nv_wdata(nv_wdata), .req_valid(req_valid),
        .req_func(req_func), .req_sub(req_sub), .req_write(req_write), .req_reg(req_reg),
        .req_count(req_count), .req_wdata(req_wdata), .nv_timeout(nv_timeout)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (app_in_valid === 1'b1)
        begin
            ev_cnt <= ev_cnt + 1;
            ev_idx <= app_in_idx;
            ev_data <= app_in_data;
            if (app_in_idx === 8'h02)
                ev2 <= app_in_data;
        end
        if (app_in_zero === 1'b1)
            zc <= zc + 1;
        if (cycles == 4000)
        begin
            mismatches = mismatches + 1;
            print_verdict;
        end
    end

    task print_verdict;
        begin
            if (mismatches == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e)
            begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask

    task xfer(input [7:0] f, input [7:0] s, input w, input [15:0] r, input [15:0] c,
        input [15:0] d);
        begin
            m.send(f, s, w, r, c, d, v, rd, ex);
            @(negedge clk);
        end
    endtask

    task do_reset;
        begin
            @(negedge clk);
            rst = 1'b1;
            repeat (8) @(negedge clk);
            rst = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask

    initial
    begin
        rst = 1'b1;
        mode_cyclic = 1'b0;
        link_running = 1'b0;
        hwf = 1'b0;
        app_we = 1'b0;
        app_wide = 1'b1;
        wide_in = 256'h0;
        {mismatches, checked, cycles, ev_cnt, zc} = 160'h0;
        {ev_idx, ev_data, ev2} = 72'h0;
        // row: function, subcode, write nibble, exception nibble, register, count
        tab[0] = 56'h03_0000_0200_0010;
        tab[1] = 56'h10_0010_0100_0001;
        tab[2] = 56'h17_0000_0001_0001;
        tab[3] = 56'h17_0010_0007_0001;
        tab[4] = 56'h04_0001_0001_0001;
        tab[5] = 56'h2B_0D01_0000_0001;
        tab[6] = 56'h03_0011_0001_0001;
        tab[7] = 56'h03_0002_0206_0001;
        tab[8] = 56'h03_0003_0001_0011;
        tab[9] = 56'h05_0001_0001_0011;
        do_reset;
        chk(timeout_ms, 32'h0000_0000);
        chk(idle, 32'h0000_0000);
        e0 = ev_cnt;
        xfer(8'h06, 8'h00, 1'b1, 16'h0001, 16'h0001, 16'h1234);
        chk({v, ex}, 32'h0000_0100);
        chk({ev_idx, ev_data[23:0]}, 32'h0000_1234);
        xfer(8'h06, 8'h00, 1'b1, 16'h0002, 16'h0001, 16'h8000);
        chk(ev_cnt - e0, 32'h0000_0001);
        xfer(8'h03, 8'h00, 1'b0, 16'h0101, 16'h0001, 16'h0000);
        chk(rd, 32'h0000_8000);
        app_we = 1'b1;
        @(negedge clk);
        app_we = 1'b0;
        xfer(8'h03, 8'h00, 1'b0, 16'h0101, 16'h0001, 16'h0000);
        chk(rd, 32'h0000_55AA);
        xfer(8'h03, 8'h00, 1'b0, 16'h0102, 16'h0001, 16'h0000);
        chk(rd, 32'h0000_0000);
        xfer(8'h03, 8'h00, 1'b0, 16'h0103, 16'h0001, 16'h0000);
        chk(rd, 32'h0000_8000);
        for (i = 0; i < 10; i = i + 1)
        begin
            xfer(tab[i][55:48], tab[i][47:40], tab[i][36], tab[i][31:16],
                tab[i][15:0], 16'h0001);
            chk({v, ex}, {23'h0, 1'b1, 4'h0, tab[i][35:32]});
        end
        xfer(8'h2B, 8'h0E, 1'b0, 16'h0000, 16'h0001, 16'h0000);
        chk(rd, VEN);
        xfer(8'h2B, 8'h0E, 1'b0, 16'h0001, 16'h0001, 16'h0000);
        chk(rd, PRD);
        xfer(8'h06, 8'h00, 1'b1, 16'h0205, 16'h0001, 16'h0003);
        chk(idle, 32'h0000_0001);
        xfer(8'h06, 8'h00, 1'b1, 16'h0205, 16'h0001, 16'h0000);
        chk(idle, 32'h0000_0000);
        wide_in[4] = 1'b1;
        e0 = ev_cnt;
        xfer(8'h06, 8'h00, 1'b1, 16'h0005, 16'h0001, 16'h1111);
        chk(ev_cnt - e0, 32'h0000_0000);
        xfer(8'h06, 8'h00, 1'b1, 16'h0006, 16'h0001, 16'h2222);
        chk({ev_idx, ev_data}, {8'h05, 32'h2222_1111});
        hwf = 1'b1;
        xfer(8'h06, 8'h00, 1'b1, 16'h0005, 16'h0001, 16'hAAAA);
        xfer(8'h06, 8'h00, 1'b1, 16'h0006, 16'h0001, 16'hBBBB);
        chk(ev_data, 32'hAAAA_BBBB);
        hwf = 1'b0;
        e0 = ev_cnt;
        xfer(8'h06, 8'h00, 1'b1, 16'h0005, 16'h0001, 16'h0000);
        xfer(8'h06, 8'h00, 1'b1, 16'h0006, 16'h0001, 16'h8000);
        chk(ev_cnt - e0, 32'h0000_0000);
        xfer(8'h06, 8'h00, 1'b1, 16'h0204, 16'h0001, 16'h0002);
        chk({timeout_ms, nv_timeout}, 32'h0002_0002);
        do_reset;
        chk(timeout_ms, 32'h0000_0002);
        xfer(8'h03, 8'h00, 1'b0, 16'h0001, 16'h0001, 16'h0000);
        repeat (24) @(negedge clk);
        chk(conn_lost, 32'h0000_0000);
        repeat (10) @(negedge clk);
        chk(conn_lost, 32'h0000_0001);
        xfer(8'h03, 8'h00, 1'b0, 16'h0001, 16'h0001, 16'h0000);
        chk(conn_lost, 32'h0000_0000);
        xfer(8'h06, 8'h00, 1'b1, 16'h0204, 16'h0001, 16'h0000);
        chk(timeout_ms, 32'h0000_0000);
        mode_cyclic = 1'b1;
        do_reset;
        xfer(8'h03, 8'h00, 1'b0, 16'h0102, 16'h0001, 16'h0000);
        chk(rd, 32'h0000_0000);
        e0 = ev_cnt;
        xfer(8'h06, 8'h00, 1'b1, 16'h0003, 16'h0001, 16'h0007);
        chk(ev_cnt - e0, 32'h0000_0000);
        link_running = 1'b1;
        xfer(8'h03, 8'h00, 1'b0, 16'h0102, 16'h0001, 16'h0000);
        chk({v, rd}, 32'h0001_0000);
        repeat (270) @(negedge clk);
        chk(ev_cnt - e0, 32'h0000_00FF);
        chk(ev2, 32'h0000_0007);
        e0 = zc;
        link_running = 1'b0;
        repeat (3) @(negedge clk);
        chk(zc - e0, 32'h0000_0001);
        e0 = ev_cnt;
        xfer(8'h06, 8'h00, 1'b1, 16'h0003, 16'h0001, 16'h0009);
        chk(ev_cnt - e0, 32'h0000_0000);
        print_verdict;
    end
endmodule // test_fieldbus_register_exchange
